// ===== inc/fba_pkg.sv
`default_nettype none
package fba_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 23;
  localparam int TAG_W      = 19;
  localparam int LINE_LSB   = 4;
  localparam int HALF_BIT   = 3;
  localparam int WORD_BIT   = 2;
  localparam int MAP_BIT    = 21;
  localparam int SHADOW_BIT = 22;
  localparam int BLK_LSB    = 18;
  localparam int BLK_W      = 3;
  localparam int NBLK       = 8;
  localparam int NMST       = 4;
  localparam int NMAP       = 2;
  localparam int BAT_W      = 5;
  localparam int Q_DEPTH    = 2;
  localparam int ST_N       = 6;
  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PROT = 8'h04;
  localparam logic [7:0] REG_BAT0 = 8'h08;
  localparam logic [7:0] REG_BAT1 = 8'h0C;
  localparam logic [7:0] REG_LOCK = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam logic [7:0] REG_EADR = 8'h1C;
  localparam logic [7:0] REG_PE   = 8'h20;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [8:0] LOCK_RST = 9'h1FF;
  localparam int CTRL_BUF = 0;
  localparam int CTRL_PF  = 1;
  localparam int PROT_WR  = 4;
  localparam int PE_START = 0;
  localparam int PE_SUSP  = 1;
  localparam int PE_RES   = 2;
  localparam int PE_SEL   = 8;
  localparam int ST_SBE   = 0;
  localparam int ST_DBE   = 1;
  localparam int ST_PROT  = 2;
  localparam int ST_ALIGN = 3;
  localparam int ST_LOCK  = 4;
  localparam int ST_PED   = 5;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_DWORD = 2'h3;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ACMD_RD = 2'b00, ACMD_PGM = 2'b01} fba_acmd_e;
  typedef enum logic [1:0] {
    K_DEM = 2'b00, K_PF = 2'b01, K_PGM = 2'b10
  } fba_kind_e;
  typedef struct packed {
    logic              req;
    logic              write;
    logic              ifetch;
    logic [1:0]        master;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
    logic [63:0]       wdata;
  } fba_bus_req_s;
  typedef struct packed {
    logic        done;
    logic        err;
    logic [63:0] rdata;
  } fba_bus_rsp_s;
  typedef struct packed {
    logic              req;
    fba_acmd_e         cmd;
    logic [ADDR_W-1:0] addr;
    logic [63:0]       wdata;
    logic [7:0]        wchk;
  } fba_arr_req_s;
  typedef struct packed {
    logic         ack;
    logic [127:0] rdata;
    logic [15:0]  chk;
  } fba_arr_rsp_s;
  // ---------------------------------------------------------------
  // secded over 64 bits: hamming position of each data bit
  // ---------------------------------------------------------------
  function automatic logic [6:0] eccPos(input int idx);
    logic [6:0] p;
    p = 7'h03;
    for (int i = 0; i < 64; i++) begin
      if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
      if (i == idx) return p;
      p = p + 7'h01;
    end
    return p;
  endfunction : eccPos
  function automatic logic [7:0] eccCode(input logic [63:0] d);
    logic [6:0] h;
    h = 7'h00;
    for (int i = 0; i < 64; i++) begin
      if (d[i]) h = h ^ eccPos(i);
    end
    return {^{d, h}, h};
  endfunction : eccCode
endpackage : fba_pkg
`default_nettype wire

// ===== rtl/fba_ecc.sv
`default_nettype none
module fba_ecc (
  // raw line from the array
  input  wire logic [127:0] line,
  input  wire logic [15:0]  chk,
  // corrected line and error flags
  output logic      [127:0] fixed,
  output logic              sbe,
  output logic              dbe
);
  logic [63:0] d;
  logic [7:0]  c;
  logic [6:0]  syn;
  logic        pe;

  always_comb begin
    fixed = line;
    sbe   = 1'b0;
    dbe   = 1'b0;
    d     = '0;
    c     = '0;
    syn   = '0;
    pe    = 1'b0;
    for (int h = 0; h < 2; h++) begin
      d   = line[h*64 +: 64];
      c   = chk[h*8 +: 8];
      syn = 7'(fba_pkg::eccCode(d) ^ {1'b0, c[6:0]});
      pe  = ^{d, c};
      // odd parity flip means one bit; syndrome names it
      for (int i = 0; i < 64; i++) begin
        if (pe && syn == fba_pkg::eccPos(i)) d[i] = ~d[i];
      end
      fixed[h*64 +: 64] = d;
      sbe = sbe | pe;
      dbe = dbe | (syn != 7'h00 && !pe);
    end
  end
endmodule : fba_ecc
`default_nettype wire

// ===== rtl/fba_line_buf.sv
`default_nettype none
module fba_line_buf #(
  parameter int NLINE = 4
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // lookups
  input  wire logic [fba_pkg::TAG_W-1:0] lkTag,
  output logic                          lkHit,
  output logic      [127:0]             lkData,
  input  wire logic [fba_pkg::TAG_W-1:0] lk2Tag,
  output logic                          lk2Hit,
  // fill and flush
  input  wire logic                     fillEn,
  input  wire logic [fba_pkg::TAG_W-1:0] fillTag,
  input  wire logic [127:0]             fillData,
  input  wire logic                     inv
);
  typedef struct packed {
    logic [NLINE-1:0]                     valid;
    logic [NLINE-1:0][fba_pkg::TAG_W-1:0] tag;
    logic [NLINE-1:0][127:0]              data;
    logic [$clog2(NLINE)-1:0]             victim;
  } fba_lb_s;
  fba_lb_s s_r, s_nxt;
  logic [$clog2(NLINE)-1:0] slot;
  logic                     found;

  always_comb begin
    s_nxt  = s_r;
    lkHit  = 1'b0;
    lk2Hit = 1'b0;
    lkData = '0;
    slot   = s_r.victim;
    found  = 1'b0;
    for (int i = 0; i < NLINE; i++) begin
      if (s_r.valid[i] && s_r.tag[i] == lkTag) begin
        lkHit  = 1'b1;
        lkData = s_r.data[i];
      end
      if (s_r.valid[i] && s_r.tag[i] == lk2Tag) lk2Hit = 1'b1;
      if (s_r.valid[i] && s_r.tag[i] == fillTag && !found) begin
        slot  = i[$clog2(NLINE)-1:0];
        found = 1'b1;
      end
    end
    // refill an existing copy in place so no tag lives twice
    if (fillEn) begin
      s_nxt.valid[slot] = 1'b1;
      s_nxt.tag[slot]   = fillTag;
      s_nxt.data[slot]  = fillData;
      if (!found) s_nxt.victim = s_r.victim + 1'b1;
    end
    if (inv) s_nxt.valid = '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end
endmodule : fba_line_buf
`default_nettype wire

// ===== rtl/fba_top.sv
`default_nettype none
module fba_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // system bus
  input  wire fba_pkg::fba_bus_req_s bus,
  output fba_pkg::fba_bus_rsp_s      busRsp,
  // array controller
  output fba_pkg::fba_arr_req_s      arr,
  input  wire fba_pkg::fba_arr_rsp_s arrRsp,
  // erase engine of the array
  output logic                       ersReq,
  output logic [3:0]                 ersBlk,
  output logic                       ersSuspend,
  input  wire logic                  ersDone,
  // protection straps, caught after reset
  input  wire logic [7:0]            protStrap,
  // register port
  input  wire logic [7:0]            regAddr,
  input  wire logic [31:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic [31:0]                regRdata,
  // interrupt
  output logic                       irq
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_WAIT = 2'b01, S_DELAY = 2'b10
  } fba_st_e;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_SCAN = 2'b01, E_WAIT = 2'b10
  } fba_es_e;
  typedef struct packed {
    fba_st_e                                  st;
    fba_es_e                                  es;
    fba_pkg::fba_bus_rsp_s                    rsp;
    logic                                     rspErr;
    logic                                     reqHalf;
    logic [fba_pkg::BAT_W-1:0]                dly;
    fba_pkg::fba_arr_req_s                    arr;
    logic [fba_pkg::Q_DEPTH-1:0][1:0]         qKind;
    logic [fba_pkg::Q_DEPTH-1:0][fba_pkg::ADDR_W-1:0] qAddr;
    logic [1:0]                               qCnt;
    logic                                     pfPend;
    logic [fba_pkg::TAG_W-1:0]                pfTag;
    logic [31:0]                              pgmLo;
    logic                                     ersReq;
    logic [3:0]                               ersBlk;
    logic                                     ersSusp;
    logic [fba_pkg::NBLK:0]                   ersSel;
    logic [1:0]                               ctrl;
    logic [7:0]                               prot;
    logic                                     strapped;
    logic [fba_pkg::NMAP-1:0][fba_pkg::BAT_W-1:0] bat;
    logic [fba_pkg::NBLK:0]                   lock;
    logic [fba_pkg::ST_N-1:0]                 stat;
    logic [fba_pkg::ST_N-1:0]                 mask;
    logic [fba_pkg::ADDR_W-1:0]               eccAddr;
    logic [31:0]                              regRdata;
    logic                                     irq;
  } fba_state_s;
  fba_state_s s_r, s_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [fba_pkg::TAG_W-1:0] tagOf(
    input logic [fba_pkg::ADDR_W-1:0] a);
    return a[fba_pkg::ADDR_W-1:fba_pkg::LINE_LSB];
  endfunction : tagOf

  function automatic logic [63:0] halfOf(input logic [127:0] l,
                                         input logic h);
    return h ? l[127:64] : l[63:0];
  endfunction : halfOf

  // ---------------------------------------------------------------
  // line buffers and ecc
  // ---------------------------------------------------------------
  logic                      lkHit;
  logic                      lk2Hit;
  logic [127:0]              lkData;
  logic                      fillEn;
  logic [fba_pkg::TAG_W-1:0] fillTag;
  logic                      inv;
  logic [127:0]              fixed;
  logic                      sbe;
  logic                      dbe;

  fba_line_buf #(.NLINE(4)) u_lb (
    .clk      (clk),
    .rst_n    (rst_n),
    .lkTag    (tagOf(bus.addr)),
    .lkHit    (lkHit),
    .lkData   (lkData),
    .lk2Tag   (s_r.pfTag),
    .lk2Hit   (lk2Hit),
    .fillEn   (fillEn),
    .fillTag  (fillTag),
    .fillData (fixed),
    .inv      (inv)
  );

  fba_ecc u_ecc (
    .line  (arrRsp.rdata),
    .chk   (arrRsp.chk),
    .fixed (fixed),
    .sbe   (sbe),
    .dbe   (dbe)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic                        push;
  logic [1:0]                  pushKind;
  logic [fba_pkg::ADDR_W-1:0]  pushAddr;
  logic [63:0]                 pushData;
  logic                        room;
  logic                        peFree;
  logic                        mapSel;
  logic [3:0]                  blk;
  logic [fba_pkg::ST_N-1:0]    setStat;
  logic [fba_pkg::ST_N-1:0]    clrStat;
  logic                        queued;
  logic [1:0]                  cnt;
  logic                        wordOk;
  logic                        sent;

  always_comb begin
    s_nxt            = s_r;
    s_nxt.rsp.done   = 1'b0;
    s_nxt.rsp.err    = 1'b0;
    s_nxt.arr.req    = 1'b0;
    s_nxt.ersReq     = 1'b0;
    s_nxt.regRdata   = '0;
    push     = 1'b0;
    pushKind = fba_pkg::K_DEM;
    pushAddr = bus.addr;
    pushData = bus.wdata;
    fillEn   = 1'b0;
    fillTag  = tagOf(s_r.qAddr[0]);
    inv      = 1'b0;
    setStat  = '0;
    clrStat  = '0;
    cnt      = s_r.qCnt;
    sent     = 1'b0;
    room     = s_r.qCnt < 2'(fba_pkg::Q_DEPTH);
    peFree   = s_r.es == E_IDLE || s_r.ersSusp;
    mapSel   = bus.addr[fba_pkg::MAP_BIT];
    blk      = bus.addr[fba_pkg::SHADOW_BIT] ? 4'(fba_pkg::NBLK)
             : 4'(bus.addr[fba_pkg::BLK_LSB +: fba_pkg::BLK_W]);
    wordOk   = (bus.size == fba_pkg::SZ_WORD && bus.addr[1:0] == 2'h0)
            || (bus.size == fba_pkg::SZ_DWORD && bus.addr[2:0] == 3'h0);
    queued   = 1'b0;
    for (int i = 0; i < fba_pkg::Q_DEPTH; i++) begin
      if (i < int'(s_r.qCnt) && tagOf(s_r.qAddr[i]) == s_r.pfTag)
        queued = 1'b1;
    end

    // straps give the permissions until software rewrites them
    if (!s_r.strapped) begin
      s_nxt.strapped = 1'b1;
      s_nxt.prot     = protStrap;
    end

    // -------------------------------------------------------------
    // array answers, in issue order
    // -------------------------------------------------------------
    if (arrRsp.ack && s_r.qCnt != 2'h0) begin
      cnt = s_r.qCnt - 2'h1;
      if (s_r.qKind[0] == fba_pkg::K_PGM) begin
        inv = 1'b1;
        s_nxt.rsp.done = 1'b1;
        s_nxt.st       = S_IDLE;
      end else begin
        if (sbe && !dbe) begin
          setStat[fba_pkg::ST_SBE] = 1'b1;
          s_nxt.eccAddr = s_r.qAddr[0];
        end
        if (dbe) setStat[fba_pkg::ST_DBE] = 1'b1;
        fillEn = !dbe && s_r.ctrl[fba_pkg::CTRL_BUF];
        if (s_r.qKind[0] == fba_pkg::K_DEM) begin
          s_nxt.rsp.rdata = halfOf(fixed, s_r.reqHalf);
          s_nxt.rspErr    = dbe;
          if (s_r.bat[s_r.qAddr[0][fba_pkg::MAP_BIT]] == '0) begin
            s_nxt.rsp.done = 1'b1;
            s_nxt.rsp.err  = dbe;
            s_nxt.st       = S_IDLE;
          end else begin
            s_nxt.dly = s_r.bat[s_r.qAddr[0][fba_pkg::MAP_BIT]]
                      - 5'h01;
            s_nxt.st  = S_DELAY;
          end
        end
      end
      s_nxt.qKind[0] = s_r.qKind[1];
      s_nxt.qAddr[0] = s_r.qAddr[1];
    end

    if (s_r.st == S_DELAY) begin
      if (s_r.dly == '0) begin
        s_nxt.rsp.done = 1'b1;
        s_nxt.rsp.err  = s_r.rspErr;
        s_nxt.st       = S_IDLE;
      end else begin
        s_nxt.dly = s_r.dly - 5'h01;
      end
    end

    // -------------------------------------------------------------
    // pending prefetch, only when no demand wants the slot
    // -------------------------------------------------------------
    if (s_r.pfPend && room && peFree
        && !(s_r.st == S_IDLE && bus.req)) begin
      s_nxt.pfPend = 1'b0;
      if (!lk2Hit && !queued) begin
        push     = 1'b1;
        pushKind = fba_pkg::K_PF;
        pushAddr = {s_r.pfTag, 4'h0};
      end
    end

    // -------------------------------------------------------------
    // new bus request; a done cycle still shows the old request
    // -------------------------------------------------------------
    if (s_r.st == S_IDLE && bus.req && !s_r.rsp.done) begin
      if (!bus.write) begin
        if (!s_r.prot[bus.master]) begin
          s_nxt.rsp.done = 1'b1;
          s_nxt.rsp.err  = 1'b1;
          setStat[fba_pkg::ST_PROT] = 1'b1;
        end else if (lkHit && s_r.ctrl[fba_pkg::CTRL_BUF]) begin
          s_nxt.rsp.done  = 1'b1;
          s_nxt.rsp.rdata = halfOf(lkData, bus.addr[fba_pkg::HALF_BIT]);
          sent = 1'b1;
        end else if (peFree && room) begin
          push           = 1'b1;
          pushKind       = fba_pkg::K_DEM;
          pushAddr       = {tagOf(bus.addr), 4'h0};
          s_nxt.reqHalf  = bus.addr[fba_pkg::HALF_BIT];
          s_nxt.st       = S_WAIT;
          sent           = 1'b1;
        end
        if (sent && bus.ifetch && s_r.ctrl[fba_pkg::CTRL_PF]
            && s_r.ctrl[fba_pkg::CTRL_BUF]) begin
          s_nxt.pfPend = 1'b1;
          s_nxt.pfTag  = tagOf(bus.addr) + 19'h00001;
        end
      end else if (!wordOk) begin
        s_nxt.rsp.done = 1'b1;
        s_nxt.rsp.err  = 1'b1;
        setStat[fba_pkg::ST_ALIGN] = 1'b1;
      end else if (!s_r.prot[fba_pkg::PROT_WR + int'(bus.master)]) begin
        s_nxt.rsp.done = 1'b1;
        s_nxt.rsp.err  = 1'b1;
        setStat[fba_pkg::ST_PROT] = 1'b1;
      end else if (s_r.lock[blk]) begin
        s_nxt.rsp.done = 1'b1;
        s_nxt.rsp.err  = 1'b1;
        setStat[fba_pkg::ST_LOCK] = 1'b1;
      end else if (bus.size == fba_pkg::SZ_WORD
                   && !bus.addr[fba_pkg::WORD_BIT]) begin
        s_nxt.pgmLo    = bus.wdata[31:0];
        s_nxt.rsp.done = 1'b1;
      end else if (peFree && room) begin
        push     = 1'b1;
        pushKind = fba_pkg::K_PGM;
        pushAddr = {bus.addr[fba_pkg::ADDR_W-1:3], 3'h0};
        if (bus.size == fba_pkg::SZ_WORD)
          pushData = {bus.wdata[63:32], s_r.pgmLo};
        s_nxt.pgmLo = '1;
        s_nxt.st    = S_WAIT;
      end
    end

    // -------------------------------------------------------------
    // issue to the array and queue bookkeeping
    // -------------------------------------------------------------
    if (push) begin
      s_nxt.arr.req     = 1'b1;
      s_nxt.arr.cmd     = pushKind == fba_pkg::K_PGM ? fba_pkg::ACMD_PGM
                                                     : fba_pkg::ACMD_RD;
      s_nxt.arr.addr    = pushAddr;
      s_nxt.arr.wdata   = pushData;
      s_nxt.arr.wchk    = fba_pkg::eccCode(pushData);
      s_nxt.qKind[cnt[0]] = pushKind;
      s_nxt.qAddr[cnt[0]] = pushAddr;
      cnt = cnt + 2'h1;
    end
    s_nxt.qCnt = cnt;

    // -------------------------------------------------------------
    // embedded erase sequence
    // -------------------------------------------------------------
    case (s_r.es)
      E_SCAN: begin
        if (s_r.ersSel == '0) begin
          setStat[fba_pkg::ST_PED] = 1'b1;
          s_nxt.es = E_IDLE;
        end else if (!s_r.ersSusp && s_r.qCnt == 2'h0) begin
          for (int i = fba_pkg::NBLK; i >= 0; i--) begin
            if (s_r.ersSel[i]) s_nxt.ersBlk = 4'(i);
          end
          s_nxt.ersSel[s_nxt.ersBlk] = 1'b0;
          if (s_r.lock[s_nxt.ersBlk]) begin
            setStat[fba_pkg::ST_LOCK] = 1'b1;
          end else begin
            s_nxt.ersReq = 1'b1;
            s_nxt.es     = E_WAIT;
          end
        end
      end
      E_WAIT: begin
        if (ersDone) begin
          inv      = 1'b1;
          s_nxt.es = E_SCAN;
        end
      end
      default: s_nxt.es = E_IDLE;
    endcase

    // -------------------------------------------------------------
    // register port
    // -------------------------------------------------------------
    if (regWr) begin
      case (regAddr)
        fba_pkg::REG_CTRL: s_nxt.ctrl = regWdata[1:0];
        fba_pkg::REG_PROT: s_nxt.prot = regWdata[7:0];
        fba_pkg::REG_BAT0: s_nxt.bat[0] = regWdata[4:0];
        fba_pkg::REG_BAT1: s_nxt.bat[1] = regWdata[4:0];
        fba_pkg::REG_LOCK: s_nxt.lock = regWdata[8:0];
        fba_pkg::REG_STAT: clrStat = regWdata[fba_pkg::ST_N-1:0];
        fba_pkg::REG_MASK: s_nxt.mask = regWdata[fba_pkg::ST_N-1:0];
        fba_pkg::REG_PE: begin
          if (regWdata[fba_pkg::PE_START] && s_r.es == E_IDLE) begin
            s_nxt.ersSel = regWdata[fba_pkg::PE_SEL +: 9];
            s_nxt.es     = E_SCAN;
          end
          if (regWdata[fba_pkg::PE_SUSP] && s_r.es != E_IDLE)
            s_nxt.ersSusp = 1'b1;
          if (regWdata[fba_pkg::PE_RES]) s_nxt.ersSusp = 1'b0;
        end
        default: ;
      endcase
    end
    if (s_nxt.es == E_IDLE) s_nxt.ersSusp = 1'b0;
    if (regRd) begin
      case (regAddr)
        fba_pkg::REG_CTRL: s_nxt.regRdata = 32'(s_r.ctrl);
        fba_pkg::REG_PROT: s_nxt.regRdata = 32'(s_r.prot);
        fba_pkg::REG_BAT0: s_nxt.regRdata = 32'(s_r.bat[0]);
        fba_pkg::REG_BAT1: s_nxt.regRdata = 32'(s_r.bat[1]);
        fba_pkg::REG_LOCK: s_nxt.regRdata = 32'(s_r.lock);
        fba_pkg::REG_STAT: s_nxt.regRdata = 32'(s_r.stat);
        fba_pkg::REG_MASK: s_nxt.regRdata = 32'(s_r.mask);
        fba_pkg::REG_EADR: s_nxt.regRdata = 32'(s_r.eccAddr);
        fba_pkg::REG_PE:
          s_nxt.regRdata = {30'h0, s_r.ersSusp, s_r.es != E_IDLE};
        default: s_nxt.regRdata = '0;
      endcase
    end
    // an event in the clearing cycle survives the clear
    s_nxt.stat = (s_r.stat & ~clrStat) | setStat;
    s_nxt.irq  = |(s_r.stat & s_r.mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.st    <= S_IDLE;
      s_r.es    <= E_IDLE;
      s_r.ctrl  <= fba_pkg::CTRL_RST;
      s_r.lock  <= fba_pkg::LOCK_RST;
      s_r.pgmLo <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busRsp     = s_r.rsp;
  assign arr        = s_r.arr;
  assign ersReq     = s_r.ersReq;
  assign ersBlk     = s_r.ersBlk;
  assign ersSuspend = s_r.ersSusp;
  assign regRdata   = s_r.regRdata;
  assign irq        = s_r.irq;
endmodule : fba_top
`default_nettype wire

// ===== verification/fba_top_sva.sv
`default_nettype none
module fba_top_sva (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire fba_pkg::fba_bus_req_s bus,
  input wire fba_pkg::fba_bus_rsp_s busRsp,
  input wire fba_pkg::fba_arr_req_s arr,
  input wire logic                  ersReq,
  input wire logic                  ersSuspend,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [7:0]            regAddr,
  input wire logic [31:0]           regWdata,
  input wire logic [31:0]           regRdata,
  input wire logic                  irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence maskOff;
    regWr && regAddr == fba_pkg::REG_MASK && regWdata == 32'h0;
  endsequence
  a_done_pulse: assert property (busRsp.done |=> !busRsp.done)
    else $error("done too long");
  a_err_done: assert property (busRsp.err |-> busRsp.done)
    else $error("err without done");
  a_line_read: assert property (arr.req && arr.cmd == fba_pkg::ACMD_RD
    |-> arr.addr[3:0] == 4'h0) else $error("read not line aligned");
  a_pgm_page: assert property (arr.req && arr.cmd == fba_pkg::ACMD_PGM
    |-> arr.addr[2:0] == 3'h0) else $error("program not page aligned");
  a_narrow_wr: assert property (bus.req && bus.write
    && bus.size < fba_pkg::SZ_WORD |=> !(arr.req
    && arr.cmd == fba_pkg::ACMD_PGM)) else $error("narrow write programmed");
  a_ers_run: assert property (ersReq |-> !ersSuspend)
    else $error("erase issued while suspended");
  a_rd_slot: assert property (regRdata != 32'h0 |-> $past(regRd))
    else $error("read data outside slot");
  a_mask_irq: assert property (maskOff |=> ##1 !irq)
    else $error("irq with mask clear");
endmodule : fba_top_sva
bind fba_top fba_top_sva u_sva (.clk, .rst_n, .bus, .busRsp, .arr, .ersReq,
  .ersSuspend, .regWr, .regRd, .regAddr, .regWdata, .regRdata, .irq);
`default_nettype wire

// ===== verification/fba_arr_model.sv
`default_nettype none
module fba_arr_model (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire fba_pkg::fba_arr_req_s arr,
  input wire logic                  ersReq,
  input wire logic [1:0]            bad,
  output fba_pkg::fba_arr_rsp_s     rsp,
  output logic                      ersDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]       ackR;
  logic [1:0][18:0] lineR;
  logic [127:0]     d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackR <= 2'h0;
      lineR <= '0;
      ersDone <= 1'b0;
    end else begin
      // two-cycle access; with the registered return that is three waits
      ackR <= {ackR[0], arr.req};
      lineR <= {lineR[0], arr.addr[22:4]};
      ersDone <= ersReq;
    end
  end
  // released data lines show the inverse, never a stale copy
  always_comb begin
    d = {~{13'h0, lineR[1]}, ~{13'h0, lineR[1]}, {13'h0, lineR[1]},
         ~{13'h0, lineR[1]}};
    rsp.ack = ackR[1];
    rsp.chk = {fba_pkg::eccCode(d[127:64]), fba_pkg::eccCode(d[63:0])};
    rsp.rdata = ackR[1] ? d ^ {126'h0, bad} : ~d;
  end
endmodule : fba_arr_model
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [1:0] bad = 2'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, rv;
  logic irq, ersReq, ersSuspend, ersDone;
  logic [3:0] ersBlk;
  logic [22:0] a;
  fba_pkg::fba_bus_req_s bus = '0;
  fba_pkg::fba_bus_rsp_s busRsp;
  fba_pkg::fba_arr_req_s arr;
  fba_pkg::fba_arr_rsp_s arrRsp;
  int errors = 0, compares = 0, n;
  fba_top uut (.clk, .rst_n, .bus, .busRsp, .arr, .arrRsp, .ersReq, .ersBlk,
    .ersSuspend, .ersDone, .protStrap(8'hFF), .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .irq);
  fba_arr_model u_arr (.clk, .rst_n, .arr, .ersReq, .bad, .rsp(arrRsp),
    .ersDone);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic rw(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk) {regAddr, regWdata, regWr} <= {ad, v, 1'b1};
    @(posedge clk) regWr <= 1'b0;
  endtask : rw
  task automatic rr(input logic [7:0] ad);
    @(posedge clk) {regAddr, regRd} <= {ad, 1'b1};
    @(posedge clk) regRd <= 1'b0;
    @(posedge clk) rv = regRdata;
  endtask : rr
  // n counts edges from request to the sampled done: hit 2, miss 5 + extra
  task automatic op(input logic w, f, input logic [1:0] m, s, input
    logic [22:0] ad);
    @(posedge clk) bus <= {1'b1, w, f, m, s, ad, 9'h0, ad, 9'h0, ad};
    n = 0;
    do begin @(posedge clk); n++; end while (!busRsp.done && n < 200);
    if (!busRsp.done) errors++;
    bus.req <= 1'b0;
  endtask : op
  function automatic logic [63:0] ex(input logic [22:0] ad);
    logic [31:0] w;
    w = {13'h0, ad[22:4]};
    return ad[3] ? {~w, ~w} : {w, ~w};
  endfunction : ex
  initial begin #2000000; errors++; conclude(); end
  initial begin
    void'($urandom(32'hA061D940));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rr(fba_pkg::REG_CTRL); chk(rv, 32'h3);
    rr(fba_pkg::REG_LOCK); chk(rv, 32'h1FF);
    rr(fba_pkg::REG_PROT); chk(rv, 32'hFF);
    rr(8'hFC); chk(rv, 32'h0);
    rw(fba_pkg::REG_BAT0, 32'h0);
    rw(fba_pkg::REG_BAT1, 32'h5);
    for (int i = 0; i < 8; i++) begin
      a = 23'($urandom);
      a[22] = 1'b0;
      a[21] = i[0];
      op(1'b0, 1'b0, i[1:0], i[2:1], a); chk(busRsp.rdata, ex(a));
      chk(n, a[21] ? 10 : 5);
      op(1'b0, 1'b0, i[1:0], 2'h3, a); chk(n, 2);
      a[21:20] = 2'h0;
      op(1'b0, i[0], 2'h0, 2'h3, a);
      repeat (4) @(posedge clk);
      op(1'b0, 1'b0, 2'h0, 2'h3, a + 23'h10); chk(n, i[0] ? 2 : 5);
      chk(busRsp.rdata, ex(a + 23'h10));
    end
    rw(fba_pkg::REG_MASK, 32'h3F);
    rw(fba_pkg::REG_PROT, 32'hFE);
    op(1'b0, 1'b0, 2'h0, 2'h3, a); chk(busRsp.err, 1'b1);
    rr(fba_pkg::REG_STAT); chk(rv[2], 1'b1);
    chk(irq, 1'b1);
    rw(fba_pkg::REG_STAT, 32'h3F);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rw(fba_pkg::REG_PROT, 32'hFF);
    op(1'b1, 1'b0, 2'h1, 2'h1, a & 23'h7FFFF8); chk(busRsp.err, 1'b1);
    op(1'b1, 1'b0, 2'h1, 2'h2, a | 23'h1); chk(busRsp.err, 1'b1);
    op(1'b1, 1'b0, 2'h1, 2'h3, a & 23'h7FFFF8); chk(busRsp.err, 1'b1);
    rw(fba_pkg::REG_LOCK, 32'h0);
    op(1'b1, 1'b0, 2'h1, 2'h3, a & 23'h3FFFF8); chk(busRsp.err, 1'b0);
    op(1'b1, 1'b0, 2'h2, 2'h3, 23'h400008); chk(busRsp.err, 1'b0);
    rw(fba_pkg::REG_MASK, 32'h0);
    bad <= 2'h1;
    op(1'b0, 1'b0, 2'h1, 2'h3, a ^ 23'h200);
    chk(busRsp.rdata, ex(a ^ 23'h200));
    rr(fba_pkg::REG_EADR); chk(rv, (a ^ 23'h200) & 23'h7FFFF0);
    bad <= 2'h3;
    op(1'b0, 1'b0, 2'h1, 2'h3, a ^ 23'h100); chk(busRsp.err, 1'b1);
    bad <= 2'h0;
    rw(fba_pkg::REG_PE, 32'h101);
    repeat (20) @(posedge clk);
    rr(fba_pkg::REG_STAT); chk(rv[5], 1'b1);
    chk(rv[0], 1'b1);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
